/* File: rtl/supervisory_defines.svh */
// register offsets, field positions, reset values and timing counts
`ifndef SUPERVISORY_DEFINES_SVH
`define SUPERVISORY_DEFINES_SVH
`define OFF_TEMP_CTRL 12'h000
`define OFF_DOG_STATE 12'h004
`define OFF_DOG_CONFIG 12'h008
`define OFF_SOFT_RESET 12'h00c
`define OFF_SAMPLE_CFG 12'h010
`define OFF_SUPPLY_CTRL 12'h014
`define OFF_STATUS 12'h018
`define BIT_TSD_CLEAR 0
`define BIT_WARN_CLEAR 1
`define BIT_TSD_FLAG 2
`define BIT_WARN_FLAG 3
`define BIT_KICK 0
`define BIT_DOG_CLEAR 1
`define BIT_DOG_SOFT 2
`define BIT_DOG_EXPIRED 3
`define BIT_DOG_NEAR 4
`define BIT_DOG_EN 0
`define BIT_DOG_RST_EN 1
`define POS_DOG_DELAY 4
`define BIT_SOFT_CMD 0
`define BIT_SOFT_EN 1
`define BIT_LOW_POWER 0
`define RST_STRETCH_SEL 2'h0
`define RST_DOG_DELAY 4'h0
`define DOG_BASE_PERIODS 5'h08
// oscillator tick taken as pclk/8, close to the free-running rate
`define OSC_DIV 8
`define DOG_CLK_DIV 16384
`define STRETCH_UNIT_MS 16
`define STRETCH_UNIT_CYC (`STRETCH_UNIT_MS * 16000)
`define FILTER_LEN 4'h8
`endif

/* File: rtl/supervisory_pkg.sv */
// types shared by the supervisory block
package supervisory_pkg;
  typedef enum logic [1:0] {
    seq_off,
    seq_wait_pump,
    seq_running
  } seq_state_type;
endpackage

/* File: rtl/supervisory_reset_watchdog.sv */
// supervisory reset, thermal and watchdog logic behind an apb slave
//
// Function
// - regulators start only after pump rises; all switch off when pump falls
// - charge pump is disabled during low power mode
// - power_on_reset clears all state except the thermal comparator filters and restarts the power-up sequence
// - internal_reset asserts while any monitored supply is undervoltage
// - internal_reset asserts throughout low power mode
// - enabled soft reset command asserts internal_reset and the reset pin
// - reset pin stays low 16/32/48/64 ms after internal_reset ends
// - serial interface is held in reset and rejects commands
// - bridges 1 and 2 go high impedance, pwm and direction cleared
// - converter, gpio, dac, opamps, interrupt and comparator power off
// - internal_reset clears watchdog counter and near flag, keeps expired flag
// - regulator shutdown depends on which supply caused the reset
// - thermal shutdown offs bridges and regulators until below warning
// - thermal flag cleared by clear write, power_on_reset or low power
// - warning flag latched; cleared by clear write, reset or low power
// - thermal comparator outputs are filtered against toggling
// - watchdog disabled after reset; enabled by writing watchdog_enable
// - kick restarts the timer and loads the programmed delay
// - expiry sets latched flag; cleared by clear, soft clear or reset
// - near-expiry flag rises one watchdog period before timeout
// - expiry resets the device only when reset enable and watchdog on
// - timeout is eight plus delay code watchdog periods
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
`include "supervisory_defines.svh"
module supervisory_reset_watchdog #(
  parameter int unsigned DOG_CLK_DIV = `DOG_CLK_DIV,
  parameter int unsigned STRETCH_UNIT_CYC = `STRETCH_UNIT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic power_on_reset,
  input wire logic uv_main_supply,
  input wire logic uv_internal_supply,
  input wire logic uv_pump,
  input wire logic uv_serial_io,
  input wire logic [3:0] uv_system_reg,
  input wire logic thermal_shutdown_raw,
  input wire logic over_temp_warning_raw,
  input wire logic reset_out_pin_in,
  output logic reset_out_pin_out,
  output logic reset_out_pin_oe,
  output logic internal_reset,
  output logic pump_enable,
  output logic [3:0] system_reg_enable,
  output logic bridge12_enable,
  output logic serial_reset,
  output logic peripheral_power_enable,
  output logic watchdog_near_expiry
);

  localparam logic [3:0] filt_max = `FILTER_LEN;

  // register state
  logic low_power_reg;
  logic soft_en_reg;
  logic [1:0] stretch_select_reg;
  logic watchdog_enable_reg;
  logic watchdog_reset_enable_reg;
  logic [3:0] watchdog_delay_reg;
  logic thermal_flag_reg;
  logic warning_flag_reg;
  logic watchdog_expired_reg;
  logic near_reg;
  logic low_power_d_reg;
  supervisory_pkg::seq_state_type seq_reg;

  // apb decode
  logic wr_en;
  logic rd_en;
  logic hit;
  assign wr_en = psel & penable & pwrite & ~internal_reset;
  assign rd_en = psel & penable & ~pwrite;
  always_comb begin
    case (paddr)
      `OFF_TEMP_CTRL, `OFF_DOG_STATE, `OFF_DOG_CONFIG, `OFF_SOFT_RESET,
      `OFF_SAMPLE_CFG, `OFF_SUPPLY_CTRL, `OFF_STATUS: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  logic wr_temp;
  logic wr_dog_state;
  logic wr_dog_cfg;
  logic wr_soft;
  logic wr_sample;
  logic wr_supply;
  assign wr_temp = wr_en & (paddr == `OFF_TEMP_CTRL);
  assign wr_dog_state = wr_en & (paddr == `OFF_DOG_STATE);
  assign wr_dog_cfg = wr_en & (paddr == `OFF_DOG_CONFIG);
  assign wr_soft = wr_en & (paddr == `OFF_SOFT_RESET);
  assign wr_sample = wr_en & (paddr == `OFF_SAMPLE_CFG);
  assign wr_supply = wr_en & (paddr == `OFF_SUPPLY_CTRL);
  logic kick;
  logic dog_clear;
  logic soft_cmd;
  assign kick = wr_dog_state & pwdata[`BIT_KICK];
  assign dog_clear = wr_dog_state &
    (pwdata[`BIT_DOG_CLEAR] | pwdata[`BIT_DOG_SOFT]);
  assign soft_cmd = wr_soft & pwdata[`BIT_SOFT_CMD] & soft_en_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & (~hit | (pwrite & internal_reset));
      prdata <= 32'h0000_0000;
      if (psel & ~penable & ~pwrite) begin
        case (paddr)
          `OFF_TEMP_CTRL: begin
            prdata[`BIT_TSD_FLAG] <= thermal_flag_reg;
            prdata[`BIT_WARN_FLAG] <= warning_flag_reg;
          end
          `OFF_DOG_STATE: begin
            prdata[`BIT_DOG_EXPIRED] <= watchdog_expired_reg;
            prdata[`BIT_DOG_NEAR] <= near_reg;
          end
          `OFF_DOG_CONFIG: begin
            prdata[`BIT_DOG_EN] <= watchdog_enable_reg;
            prdata[`BIT_DOG_RST_EN] <= watchdog_reset_enable_reg;
            prdata[`POS_DOG_DELAY +: 4] <= watchdog_delay_reg;
          end
          `OFF_SOFT_RESET: prdata[`BIT_SOFT_EN] <= soft_en_reg;
          `OFF_SAMPLE_CFG: prdata[1:0] <= stretch_select_reg;
          `OFF_SUPPLY_CTRL: prdata[`BIT_LOW_POWER] <= low_power_reg;
          `OFF_STATUS: begin
            prdata[0] <= internal_reset;
            prdata[1] <= reset_out_pin_in;
            prdata[5:2] <= system_reg_enable;
          end
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
  logic unused_rd;
  assign unused_rd = rd_en;

  // control registers; power_on_reset returns all to defaults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_power_reg <= 1'b0;
      soft_en_reg <= 1'b0;
      stretch_select_reg <= `RST_STRETCH_SEL;
      watchdog_enable_reg <= 1'b0;
      watchdog_reset_enable_reg <= 1'b0;
      watchdog_delay_reg <= `RST_DOG_DELAY;
    end else if (power_on_reset) begin
      low_power_reg <= 1'b0;
      soft_en_reg <= 1'b0;
      stretch_select_reg <= `RST_STRETCH_SEL;
      watchdog_enable_reg <= 1'b0;
      watchdog_reset_enable_reg <= 1'b0;
      watchdog_delay_reg <= `RST_DOG_DELAY;
    end else begin
      if (wr_supply)
        low_power_reg <= pwdata[`BIT_LOW_POWER];
      if (wr_soft)
        soft_en_reg <= pwdata[`BIT_SOFT_EN];
      if (wr_sample)
        stretch_select_reg <= pwdata[1:0];
      if (wr_dog_cfg) begin
        watchdog_enable_reg <= pwdata[`BIT_DOG_EN];
        watchdog_reset_enable_reg <= pwdata[`BIT_DOG_RST_EN];
        watchdog_delay_reg <= pwdata[`POS_DOG_DELAY +: 4];
      end
    end
  end

  // oscillator and watchdog clock enables
  localparam int unsigned osc_div = `OSC_DIV;
  logic [3:0] osc_cnt_reg;
  logic osc_tick;
  logic [15:0] dog_div_reg;
  logic dog_tick;
  assign osc_tick = (osc_cnt_reg == 4'(osc_div - 1));
  assign dog_tick = osc_tick & (dog_div_reg == 16'(DOG_CLK_DIV - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_cnt_reg <= 4'h0;
      dog_div_reg <= 16'h0000;
    end else if (power_on_reset | low_power_reg) begin
      osc_cnt_reg <= 4'h0;
      dog_div_reg <= 16'h0000;
    end else if (osc_tick) begin
      osc_cnt_reg <= 4'h0;
      dog_div_reg <= dog_tick ? 16'h0000 : dog_div_reg + 16'h0001;
    end else begin
      osc_cnt_reg <= osc_cnt_reg + 4'h1;
    end
  end

  // thermal comparator filters and flags
  logic [3:0] tsd_cnt_reg;
  logic [3:0] warn_cnt_reg;
  logic tsd_filt_reg;
  logic warn_filt_reg;
  logic lp_entry;
  assign lp_entry = low_power_reg & ~low_power_d_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tsd_cnt_reg <= 4'h0;
      warn_cnt_reg <= 4'h0;
      tsd_filt_reg <= 1'b0;
      warn_filt_reg <= 1'b0;
    end else if (osc_tick) begin
      if (thermal_shutdown_raw == tsd_filt_reg)
        tsd_cnt_reg <= 4'h0;
      else if (tsd_cnt_reg == filt_max - 4'h1) begin
        tsd_cnt_reg <= 4'h0;
        tsd_filt_reg <= thermal_shutdown_raw;
      end else
        tsd_cnt_reg <= tsd_cnt_reg + 4'h1;
      if (over_temp_warning_raw == warn_filt_reg)
        warn_cnt_reg <= 4'h0;
      else if (warn_cnt_reg == filt_max - 4'h1) begin
        warn_cnt_reg <= 4'h0;
        warn_filt_reg <= over_temp_warning_raw;
      end else
        warn_cnt_reg <= warn_cnt_reg + 4'h1;
    end
  end

  // thermal shutdown holds until the warning level is left
  logic tsd_hold_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tsd_hold_reg <= 1'b0;
      thermal_flag_reg <= 1'b0;
      warning_flag_reg <= 1'b0;
      low_power_d_reg <= 1'b0;
    end else if (power_on_reset) begin
      tsd_hold_reg <= 1'b0;
      thermal_flag_reg <= 1'b0;
      warning_flag_reg <= 1'b0;
      low_power_d_reg <= 1'b0;
    end else begin
      low_power_d_reg <= low_power_reg;
      if (tsd_filt_reg)
        tsd_hold_reg <= 1'b1;
      else if (~warn_filt_reg)
        tsd_hold_reg <= 1'b0;
      // set wins over clear
      if (tsd_filt_reg)
        thermal_flag_reg <= 1'b1;
      else if ((wr_temp & pwdata[`BIT_TSD_CLEAR]) | lp_entry)
        thermal_flag_reg <= 1'b0;
      if (warn_filt_reg)
        warning_flag_reg <= 1'b1;
      else if ((wr_temp & pwdata[`BIT_WARN_CLEAR]) | lp_entry)
        warning_flag_reg <= 1'b0;
    end
  end

  // watchdog timer
  logic [4:0] dog_cnt_reg;
  logic [4:0] dog_limit_reg;
  logic dog_expire;
  assign dog_expire = watchdog_enable_reg & dog_tick &
    (dog_cnt_reg == dog_limit_reg - 5'h01);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dog_cnt_reg <= 5'h00;
      dog_limit_reg <= `DOG_BASE_PERIODS;
    end else if (power_on_reset) begin
      dog_cnt_reg <= 5'h00;
      dog_limit_reg <= `DOG_BASE_PERIODS;
    end else if (internal_reset | ~watchdog_enable_reg) begin
      dog_cnt_reg <= 5'h00;
    end else if (kick) begin
      dog_cnt_reg <= 5'h00;
      dog_limit_reg <= `DOG_BASE_PERIODS + {1'b0, watchdog_delay_reg};
    end else if (dog_expire) begin
      dog_cnt_reg <= 5'h00;
    end else if (dog_tick) begin
      dog_cnt_reg <= dog_cnt_reg + 5'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_expired_reg <= 1'b0;
      near_reg <= 1'b0;
    end else if (power_on_reset) begin
      watchdog_expired_reg <= 1'b0;
      near_reg <= 1'b0;
    end else begin
      if (dog_expire)
        watchdog_expired_reg <= 1'b1;
      else if (dog_clear)
        watchdog_expired_reg <= 1'b0;
      near_reg <= watchdog_enable_reg & ~internal_reset & ~kick &
        (dog_cnt_reg == dog_limit_reg - 5'h01);
    end
  end

  // internal reset sources
  logic dog_reset_reg;
  logic soft_reset_reg;
  logic uv_any;
  assign uv_any = uv_main_supply | uv_internal_supply | uv_pump |
    uv_serial_io | (|uv_system_reg);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dog_reset_reg <= 1'b0;
      soft_reset_reg <= 1'b0;
      internal_reset <= 1'b1;
    end else begin
      dog_reset_reg <= dog_expire & watchdog_reset_enable_reg;
      soft_reset_reg <= soft_cmd;
      internal_reset <= power_on_reset | uv_any | low_power_reg |
        dog_reset_reg | soft_reset_reg | tsd_hold_reg;
    end
  end

  // reset pin stretch in oscillator units
  logic [23:0] unit_cnt_reg;
  logic [2:0] units_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_cnt_reg <= 24'h000000;
      units_reg <= 3'h0;
      reset_out_pin_out <= 1'b0;
      reset_out_pin_oe <= 1'b1;
    end else if (internal_reset) begin
      unit_cnt_reg <= 24'h000000;
      units_reg <= {1'b0, stretch_select_reg} + 3'h1;
      reset_out_pin_oe <= 1'b1;
    end else if (units_reg != 3'h0) begin
      reset_out_pin_oe <= 1'b1;
      if (osc_tick) begin
        if (unit_cnt_reg == 24'(STRETCH_UNIT_CYC - 1)) begin
          unit_cnt_reg <= 24'h000000;
          units_reg <= units_reg - 3'h1;
        end else
          unit_cnt_reg <= unit_cnt_reg + 24'h000001;
      end
    end else begin
      reset_out_pin_oe <= 1'b0;
    end
  end

  // regulator sequencing and shutdown
  logic [3:0] uv_first;
  always_comb begin
    uv_first[0] = uv_system_reg[0];
    for (int i = 1; i < 4; i++)
      uv_first[i] = uv_system_reg[i] | uv_first[i-1];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_reg <= supervisory_pkg::seq_off;
      system_reg_enable <= 4'h0;
      pump_enable <= 1'b0;
    end else begin
      pump_enable <= ~power_on_reset & ~low_power_reg;
      case (seq_reg)
        supervisory_pkg::seq_off: begin
          system_reg_enable <= 4'h0;
          if (~power_on_reset & ~low_power_reg & ~tsd_hold_reg)
            seq_reg <= supervisory_pkg::seq_wait_pump;
        end
        supervisory_pkg::seq_wait_pump: begin
          if (~uv_pump & ~uv_main_supply & ~uv_internal_supply)
            seq_reg <= supervisory_pkg::seq_running;
        end
        supervisory_pkg::seq_running: begin
          if (~uv_system_reg[0])
            system_reg_enable[0] <= 1'b1;
          for (int i = 1; i < 4; i++)
            if (system_reg_enable[i-1] & ~uv_first[i-1])
              system_reg_enable[i] <= 1'b1;
          if (|uv_first)
            system_reg_enable <= system_reg_enable &
              ~{uv_first[2:0], 1'b0};
        end
        default: seq_reg <= supervisory_pkg::seq_off;
      endcase
      if (power_on_reset | low_power_reg | tsd_hold_reg |
          uv_pump | uv_main_supply | uv_internal_supply) begin
        seq_reg <= supervisory_pkg::seq_off;
        system_reg_enable <= 4'h0;
      end
    end
  end

  // functions held off during internal reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bridge12_enable <= 1'b0;
      serial_reset <= 1'b1;
      peripheral_power_enable <= 1'b0;
      watchdog_near_expiry <= 1'b0;
    end else begin
      bridge12_enable <= ~internal_reset & ~tsd_hold_reg;
      serial_reset <= internal_reset;
      peripheral_power_enable <= ~internal_reset;
      watchdog_near_expiry <= near_reg;
    end
  end

  // assertions
  expire_sets_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    dog_expire && !power_on_reset |=> watchdog_expired_reg)
    else $error("expiry did not set flag");
  lowpower_resets_a: assert property (@(posedge pclk) disable iff (!presetn)
    low_power_reg |=> ##1 internal_reset)
    else $error("low power without internal reset");
  pump_off_lp_a: assert property (@(posedge pclk) disable iff (!presetn)
    low_power_reg |=> !pump_enable)
    else $error("pump on in low power");
  bridge_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    internal_reset |=> !bridge12_enable)
    else $error("bridges on during reset");
  pin_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    internal_reset |=> reset_out_pin_oe && !reset_out_pin_out)
    else $error("reset pin released during reset");
  pump_uv_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    uv_pump |=> system_reg_enable == 4'h0)
    else $error("regulator on during pump undervoltage");
  dog_disabled_a: assert property (@(posedge pclk) disable iff (!presetn)
    !watchdog_enable_reg |=> dog_cnt_reg == 5'h00)
    else $error("disabled watchdog counted");
  kick_loads_a: assert property (@(posedge pclk) disable iff (!presetn)
    kick && !internal_reset && watchdog_enable_reg && !power_on_reset
    |=> dog_cnt_reg == 5'h00 &&
      dog_limit_reg == 5'h08 + {1'b0, $past(watchdog_delay_reg)})
    else $error("kick did not reload");
endmodule // supervisory_reset_watchdog

/* File: tb/tb_top.sv */
// self-checking testbench of the supervisory reset and watchdog block
`timescale 1ns/1ps
`include "supervisory_defines.svh"
module tb_top;
  localparam int DOG_DIV = 2;
  localparam int UNIT = 4;
  localparam int WD_CYC = DOG_DIV * 8;
  localparam int STR_CYC = UNIT * 8;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic power_on_reset = 1'b0;
  logic uv_main_supply = 1'b0;
  logic uv_internal_supply = 1'b0;
  logic uv_pump = 1'b0;
  logic uv_serial_io = 1'b0;
  logic [3:0] uv_system_reg = 4'h0;
  logic thermal_shutdown_raw = 1'b0;
  logic over_temp_warning_raw = 1'b0;
  wire reset_out_pin_in;
  logic reset_out_pin_out;
  logic reset_out_pin_oe;
  logic internal_reset;
  logic pump_enable;
  logic [3:0] system_reg_enable;
  logic bridge12_enable;
  logic serial_reset;
  logic peripheral_power_enable;
  logic watchdog_near_expiry;
  int mismatches = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic err;
  logic [7:0] uv_pat [5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h20};
  logic [3:0] reg_exp [5] = '{4'h0, 4'h0, 4'h0, 4'hf, 4'h3};

  always #4 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  // pin has an external pull-up; the device only pulls it low
  assign reset_out_pin_in = reset_out_pin_oe ? reset_out_pin_out : 1'b1;

  supervisory_reset_watchdog #(
    .DOG_CLK_DIV(DOG_DIV),
    .STRETCH_UNIT_CYC(UNIT)
  ) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .power_on_reset(power_on_reset),
    .uv_main_supply(uv_main_supply),
    .uv_internal_supply(uv_internal_supply), .uv_pump(uv_pump),
    .uv_serial_io(uv_serial_io), .uv_system_reg(uv_system_reg),
    .thermal_shutdown_raw(thermal_shutdown_raw),
    .over_temp_warning_raw(over_temp_warning_raw),
    .reset_out_pin_in(reset_out_pin_in),
    .reset_out_pin_out(reset_out_pin_out),
    .reset_out_pin_oe(reset_out_pin_oe), .internal_reset(internal_reset),
    .pump_enable(pump_enable), .system_reg_enable(system_reg_enable),
    .bridge12_enable(bridge12_enable), .serial_reset(serial_reset),
    .peripheral_power_enable(peripheral_power_enable),
    .watchdog_near_expiry(watchdog_near_expiry)
  );

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_in(input string what, input int lo, input int hi,
                        input int got);
    tests_run++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi,
               got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk_in("pready wait", 1, 1, n);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic pick(input int w);
    case (w)
      0: return internal_reset;
      1: return reset_out_pin_oe;
      default: return watchdog_near_expiry;
    endcase
  endfunction

  task automatic wait_for(input string what, input int w, input logic v,
                          input int lim);
    int n;
    n = 0;
    while (pick(w) !== v && n < lim) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk(what, v, pick(w));
  endtask

  task automatic stretch(input int s);
    int t;
    wait_for("reset off", 0, 1'b0, 400);
    t = cyc;
    chk("pin driven low", 1'b0, reset_out_pin_in);
    wait_for("pin off", 1, 1'b0, 600);
    chk_in("stretch", STR_CYC * (s + 1) - 8, STR_CYC * (s + 1) + 24,
           cyc - t);
  endtask

  task automatic dog_run(input logic [3:0] d1, input logic [3:0] d2,
                         input int clr);
    int tk;
    int tn;
    apb(1'b1, `OFF_DOG_CONFIG, {24'h0, d1, 4'h3});
    apb(1'b1, `OFF_DOG_STATE, 32'h1);
    tk = cyc;
    apb(1'b1, `OFF_DOG_CONFIG, {24'h0, d2, 4'h3});
    wait_for("near", 2, 1'b1, 500);
    tn = cyc;
    wait_for("dog reset", 0, 1'b1, 100);
    chk_in("near lead", WD_CYC - 4, WD_CYC + 4, cyc - tn);
    chk_in("timeout", (7 + d1) * WD_CYC, (9 + d1) * WD_CYC + 4,
           cyc - tk);
    stretch(0);
    apb(1'b1, `OFF_DOG_CONFIG, 32'h0);
    apb(1'b0, `OFF_DOG_STATE, 32'h0);
    chk("flag kept", 1'b1, rd[`BIT_DOG_EXPIRED]);
    apb(1'b1, `OFF_DOG_STATE, 32'h1 << clr);
    apb(1'b0, `OFF_DOG_STATE, 32'h0);
    chk("flag cleared", 1'b0, rd[`BIT_DOG_EXPIRED]);
  endtask

  task automatic warm(input int len);
    over_temp_warning_raw <= 1'b1;
    repeat (len) @(posedge pclk);
    over_temp_warning_raw <= 1'b0;
    repeat (100) @(posedge pclk);
    apb(1'b0, `OFF_TEMP_CTRL, 32'h0);
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    print_verdict;
  end

  initial begin
    repeat (4) @(posedge pclk);
    #1;
    chk("reset active", 1'b1, internal_reset);
    chk("pin in reset", 1'b1, reset_out_pin_oe);
    @(posedge pclk);
    presetn <= 1'b1;
    stretch(0);
    chk("regs up", 4'hf, system_reg_enable);
    apb(1'b0, `OFF_SAMPLE_CFG, 32'h0);
    chk("stretch default", 32'h0, rd);
    apb(1'b0, `OFF_DOG_CONFIG, 32'h0);
    chk("dog off", 32'h0, rd);
    apb(1'b0, 12'hffc, 32'h0);
    chk("unmapped", 1'b1, err);
    $display("test defaults done");
    apb(1'b1, `OFF_SOFT_RESET, 32'h2);
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, `OFF_SAMPLE_CFG, s);
      apb(1'b1, `OFF_SOFT_RESET, 32'h3);
      wait_for("soft reset", 0, 1'b1, 10);
      stretch(s);
    end
    apb(1'b1, `OFF_SOFT_RESET, 32'h0);
    apb(1'b1, `OFF_SOFT_RESET, 32'h1);
    repeat (10) @(posedge pclk);
    chk("soft disabled", 1'b0, reset_out_pin_oe);
    $display("test soft reset done");
    for (int i = 0; i < 5; i++) begin
      {uv_system_reg, uv_serial_io, uv_pump, uv_internal_supply,
       uv_main_supply} <= uv_pat[i];
      wait_for("uv reset", 0, 1'b1, 10);
      repeat (5) @(posedge pclk);
      chk("regs cut", reg_exp[i], system_reg_enable);
      chk("serial held", 1'b1, serial_reset);
      chk("bridges off", 1'b0, bridge12_enable);
      chk("periph off", 1'b0, peripheral_power_enable);
      apb(1'b1, `OFF_DOG_CONFIG, 32'h1);
      chk("write refused", 1'b1, err);
      {uv_system_reg, uv_serial_io, uv_pump, uv_internal_supply,
       uv_main_supply} <= 8'h00;
      stretch(3);
      chk("regs back", 4'hf, system_reg_enable);
    end
    apb(1'b0, `OFF_DOG_CONFIG, 32'h0);
    chk("cfg ignored", 32'h0, rd);
    $display("test undervoltage done");
    apb(1'b1, `OFF_SAMPLE_CFG, 32'h0);
    apb(1'b1, `OFF_DOG_CONFIG, 32'h1);
    apb(1'b1, `OFF_DOG_STATE, 32'h1);
    repeat (WD_CYC * 12) @(posedge pclk);
    chk("no dog reset", 1'b0, internal_reset);
    apb(1'b1, `OFF_DOG_CONFIG, 32'h0);
    apb(1'b0, `OFF_DOG_STATE, 32'h0);
    chk("expired", 1'b1, rd[`BIT_DOG_EXPIRED]);
    dog_run(4'h0, 4'hf, `BIT_DOG_CLEAR);
    dog_run(4'hf, 4'h0, `BIT_DOG_SOFT);
    $display("test watchdog done");
    thermal_shutdown_raw <= 1'b1;
    wait_for("hot reset", 0, 1'b1, 150);
    chk("hot bridges", 1'b0, bridge12_enable);
    chk("hot regs", 4'h0, system_reg_enable);
    thermal_shutdown_raw <= 1'b0;
    stretch(0);
    apb(1'b0, `OFF_TEMP_CTRL, 32'h0);
    chk("hot flag", 1'b1, rd[`BIT_TSD_FLAG]);
    apb(1'b1, `OFF_TEMP_CTRL, 32'h1);
    apb(1'b0, `OFF_TEMP_CTRL, 32'h0);
    chk("hot cleared", 1'b0, rd[`BIT_TSD_FLAG]);
    warm(24);
    chk("glitch filtered", 1'b0, rd[`BIT_WARN_FLAG]);
    warm(100);
    chk("warm latched", 1'b1, rd[`BIT_WARN_FLAG]);
    apb(1'b1, `OFF_TEMP_CTRL, 32'h2);
    apb(1'b0, `OFF_TEMP_CTRL, 32'h0);
    chk("warm cleared", 1'b0, rd[`BIT_WARN_FLAG]);
    warm(100);
    $display("test thermal done");
    apb(1'b1, `OFF_SUPPLY_CTRL, 32'h1);
    wait_for("low power", 0, 1'b1, 10);
    repeat (5) @(posedge pclk);
    chk("pump off", 1'b0, pump_enable);
    apb(1'b0, `OFF_TEMP_CTRL, 32'h0);
    chk("warm on sleep", 1'b0, rd[`BIT_WARN_FLAG]);
    power_on_reset <= 1'b1;
    uv_pump <= 1'b1;
    repeat (5) @(posedge pclk);
    power_on_reset <= 1'b0;
    repeat (20) @(posedge pclk);
    chk("no pump no regs", 4'h0, system_reg_enable);
    uv_pump <= 1'b0;
    stretch(0);
    chk("restart regs", 4'hf, system_reg_enable);
    apb(1'b0, `OFF_SAMPLE_CFG, 32'h0);
    chk("por defaults", 32'h0, rd);
    $display("test low power done");
    print_verdict;
  end
endmodule // tb_top
